// ==== src/chz_defines.vh ====
// Constants for the charger input power loop and battery temperature zone control
// Assumes an 8-bit register port and a 100 MHz clock
`ifndef CHZ_DEFINES_VH
`define CHZ_DEFINES_VH

// Register offsets
`define CHZ_TEMP_CTRL_ADDR   8'h92
`define CHZ_VIN_CTRL_ADDR    8'h95
`define CHZ_ZONE_CTRL_ADDR   8'h9a
`define CHZ_CHG_CUR_ADDR     8'ha0
`define CHZ_IRQ_STAT_ADDR    8'ha1
`define CHZ_IRQ_MASK_ADDR    8'ha2
`define CHZ_LOOP_STAT_ADDR   8'ha3

// Reset values
`define CHZ_TEMP_CTRL_RST    8'h05
`define CHZ_VIN_CTRL_RST     8'h00
`define CHZ_ZONE_CTRL_RST    8'h00
`define CHZ_CHG_CUR_RST      8'h32
`define CHZ_IRQ_MASK_RST     8'h00

// Field positions in the temperature regulation control register
`define CHZ_FOLDBACK_EN_BIT  7
`define CHZ_HOT_SEL_BIT      5
`define CHZ_COLD_SEL_BIT     4
`define CHZ_SETPOINT_HI      3
`define CHZ_SETPOINT_LO      2
`define CHZ_MODE_HI          1
`define CHZ_MODE_LO          0

// Field positions in the input voltage regulation control register
`define CHZ_LOOP_DIS_BIT     5
`define CHZ_PRECHG_HI        4
`define CHZ_PRECHG_LO        3
`define CHZ_VSEL_HI          2
`define CHZ_VSEL_LO          0

// Field positions in the battery temperature zone control register
`define CHZ_CC_HI            5
`define CHZ_CC_LO            4
`define CHZ_CV_HI            3
`define CHZ_CV_LO            2
`define CHZ_COOL_BIT         1
`define CHZ_WARM_BIT         0

// Interrupt status bits
`define CHZ_IRQ_DPM_BIT      0
`define CHZ_IRQ_COOL_BIT     1
`define CHZ_IRQ_WARM_BIT     2
`define CHZ_IRQ_DROP_BIT     3

// Thermistor modes
`define CHZ_MODE_OFF         2'h0
`define CHZ_MODE_SOFT        2'h1
`define CHZ_MODE_BOTH        2'h2
`define CHZ_MODE_CUR         2'h3

// Input threshold in mV: base plus step per code, lower comparator offset
`define CHZ_VIN_BASE_MV      13'h0f3c
`define CHZ_VIN_STEP_MV      13'h0064
`define CHZ_VIN_LOW_OFS_MV   13'h00c8

// Charge voltage reductions in mV
`define CHZ_CV_RED0_MV       8'h3c
`define CHZ_CV_RED1_MV       8'h64
`define CHZ_CV_RED2_MV       8'ha0
`define CHZ_CV_RED3_MV       8'hc8

// Charge current in 10 mA units; floor level after a deep droop
`define CHZ_CUR_FLOOR        8'h0a

// Timing
`define CHZ_CLK_MHZ          100
`define CHZ_STEP_MS          10
`define CHZ_STEP_CYC         (`CHZ_STEP_MS * 1000 * `CHZ_CLK_MHZ)
`define CHZ_DEB_US           1000
`define CHZ_DEB_CYC          (`CHZ_DEB_US * `CHZ_CLK_MHZ)

// Zone codes
`define CHZ_ZONE_NORMAL      3'h0
`define CHZ_ZONE_COOL        3'h1
`define CHZ_ZONE_WARM        3'h2
`define CHZ_ZONE_COLD        3'h3
`define CHZ_ZONE_HOT         3'h4

`endif

// ==== src/chz_debounce.v ====
// Level debouncer: output follows the input once it has held steady for a set count
// Assumes a synchronous, active-high reset
`timescale 1ns/1ps
module chz_debounce #(
  parameter integer DEB_CYC = 100000
) (
  input  wire ref_clk_i,
  input  wire srst_i,
  input  wire level_i,
  output reg  level_o
);

  reg  [31:0] cnt;
  wire [31:0] last = DEB_CYC - 1;

  always @(posedge ref_clk_i) begin
    if (srst_i) begin
      cnt     <= 32'h0;
      level_o <= 1'b0;
    end else if (level_i == level_o) begin
      cnt <= 32'h0;
    end else if (cnt >= last) begin
      cnt     <= 32'h0;
      level_o <= level_i;
    end else begin
      cnt <= cnt + 32'h1;
    end
  end

endmodule // chz_debounce

// ==== src/chz_charger_ctrl.v ====
// Charger input power loop and battery temperature zone control
// Assumes synchronous comparator inputs, an 8-bit register port and a 100 MHz clock
//
// What this block does
// - Lower input current limit to hold input voltage
// - Interrupt after debounce when input loop active
// - Lower comparator trip sits 200 mV below threshold
// - Lower trip drops current to 100 mA at once
// - Then step current up every 10 ms
// - Step up only while main comparator is above
// - Three-bit threshold: 3.9 V plus 0.1 V per code
// - Five zones: stop cold/hot, adjust cool/warm
// - Zone behaviour chosen by mode field at 0x92
// - Mode 2 reduces current and voltage
// - Mode 3 reduces current only
// - Mode 1 interrupts on cool/warm crossings only
// - Mode 0 ignores the thermistor
// - Voltage reduction code: 60/100/160/200 mV
// - Current reduction code: 25/50/75/100 percent
`timescale 1ns/1ps
`include "chz_defines.vh"
module chz_charger_ctrl #(
  parameter integer STEP_CYC = `CHZ_STEP_CYC,
  parameter integer DEB_CYC  = `CHZ_DEB_CYC
) (
  input  wire        ref_clk_i,
  input  wire        srst_i,
  input  wire [7:0]  reg_addr_i,
  input  wire [7:0]  reg_wdata_i,
  input  wire        reg_wr_i,
  input  wire        reg_rd_i,
  output reg  [7:0]  reg_rdata_o,
  input  wire        vin_above_i,
  input  wire        vin_low_trip_i,
  input  wire        therm_cold_i,
  input  wire        therm_cool_i,
  input  wire        therm_warm_i,
  input  wire        therm_hot_i,
  output reg  [12:0] input_regulation_threshold_o,
  output reg  [12:0] input_low_trip_mv_o,
  output reg  [7:0]  charge_current_o,
  output reg  [7:0]  cv_reduction_mv_o,
  output reg         charge_enable_o,
  output reg         hot_threshold_select_o,
  output reg         cold_threshold_select_o,
  output reg  [2:0]  zone_o,
  output reg         irq_o
);

  // Register file
  reg  [7:0]  temp_ctrl;
  reg  [7:0]  vin_ctrl;
  reg  [3:0]  zone_ctrl;
  reg  [7:0]  prog_cur;
  wire [3:0]  irq_stat;
  reg  [3:0]  irq_mask;

  // Input loop state
  reg  [7:0]  dpm_limit;
  reg  [31:0] step_cnt;
  reg         step_tick;
  reg         dpm_trip_q;
  reg         cool_q;
  reg         warm_q;
  wire        dpm_active_deb;

  wire [1:0]  mode     = temp_ctrl[`CHZ_MODE_HI:`CHZ_MODE_LO];
  wire        loop_dis = vin_ctrl[`CHZ_LOOP_DIS_BIT];
  wire [1:0]  cc_code  = zone_ctrl[`CHZ_CC_HI-2:`CHZ_CC_LO-2];
  wire [1:0]  cv_code  = zone_ctrl[`CHZ_CV_HI-2:`CHZ_CV_LO-2];
  wire [31:0] step_last = STEP_CYC - 1;

  wire wr_temp = reg_wr_i && (reg_addr_i == `CHZ_TEMP_CTRL_ADDR);
  wire wr_vin  = reg_wr_i && (reg_addr_i == `CHZ_VIN_CTRL_ADDR);
  wire wr_zone = reg_wr_i && (reg_addr_i == `CHZ_ZONE_CTRL_ADDR);
  wire wr_cur  = reg_wr_i && (reg_addr_i == `CHZ_CHG_CUR_ADDR);
  wire wr_stat = reg_wr_i && (reg_addr_i == `CHZ_IRQ_STAT_ADDR);
  wire wr_mask = reg_wr_i && (reg_addr_i == `CHZ_IRQ_MASK_ADDR);

  // Writable bits; reserved bits are never stored and read zero
  localparam [7:0] TEMP_WR_MASK = 8'hbf;
  localparam [7:0] VIN_WR_MASK  = 8'h3f;

  // Zone decode; hot and cold take priority over warm and cool
  reg  [2:0] next_zone;
  always @* begin
    if (mode == `CHZ_MODE_OFF)
      next_zone = `CHZ_ZONE_NORMAL;
    else if (therm_hot_i)
      next_zone = `CHZ_ZONE_HOT;
    else if (therm_cold_i)
      next_zone = `CHZ_ZONE_COLD;
    else if (therm_warm_i)
      next_zone = `CHZ_ZONE_WARM;
    else if (therm_cool_i)
      next_zone = `CHZ_ZONE_COOL;
    else
      next_zone = `CHZ_ZONE_NORMAL;
  end

  wire in_cool = (next_zone == `CHZ_ZONE_COOL);
  wire in_warm = (next_zone == `CHZ_ZONE_WARM);
  wire in_adj  = in_cool || in_warm;
  wire stop    = (next_zone == `CHZ_ZONE_HOT) || (next_zone == `CHZ_ZONE_COLD);

  // Temperature-reduced target current
  reg  [7:0] red_cur;
  always @* begin
    case (cc_code)
      2'h0:    red_cur = prog_cur - {2'h0, prog_cur[7:2]};
      2'h1:    red_cur = {1'b0, prog_cur[7:1]};
      2'h2:    red_cur = {2'h0, prog_cur[7:2]};
      2'h3:    red_cur = 8'h00;
      default: red_cur = prog_cur;
    endcase
  end

  reg  [7:0] cv_red;
  always @* begin
    case (cv_code)
      2'h0:    cv_red = `CHZ_CV_RED0_MV;
      2'h1:    cv_red = `CHZ_CV_RED1_MV;
      2'h2:    cv_red = `CHZ_CV_RED2_MV;
      2'h3:    cv_red = `CHZ_CV_RED3_MV;
      default: cv_red = `CHZ_CV_RED0_MV;
    endcase
  end

  reg  [7:0] target_cur;
  reg  [7:0] next_cv_red;
  always @* begin
    target_cur  = prog_cur;
    next_cv_red = 8'h00;
    case (mode)
      `CHZ_MODE_BOTH: begin
        if (in_adj) begin
          target_cur  = red_cur;
          next_cv_red = cv_red;
        end
      end
      `CHZ_MODE_CUR: begin
        if (in_adj)
          target_cur = red_cur;
      end
      `CHZ_MODE_SOFT: begin
        target_cur = prog_cur;
      end
      default: begin
        target_cur = prog_cur;
      end
    endcase
  end

  // Step timer for current ramp
  always @(posedge ref_clk_i) begin
    if (srst_i) begin
      step_cnt  <= 32'h0;
      step_tick <= 1'b0;
    end else if (step_cnt >= step_last) begin
      step_cnt  <= 32'h0;
      step_tick <= 1'b1;
    end else begin
      step_cnt  <= step_cnt + 32'h1;
      step_tick <= 1'b0;
    end
  end

  // Input power loop current limit
  reg  [7:0] next_limit;
  always @* begin
    next_limit = dpm_limit;
    if (loop_dis) begin
      next_limit = 8'hff;
    end else if (vin_low_trip_i) begin
      // Deep droop: jump to the floor at once, no stepping
      next_limit = `CHZ_CUR_FLOOR;
    end else if (step_tick) begin
      if (vin_above_i) begin
        if (dpm_limit < target_cur) begin
          next_limit = dpm_limit + 8'h01;
        end
      end else if (dpm_limit > `CHZ_CUR_FLOOR) begin
        // Input still sagging on a tick: give back one step
        next_limit = dpm_limit - 8'h01;
      end
    end
    // Never above the target while the loop is enabled; a target under the floor leaves the floor alone
    if (!loop_dis && next_limit > target_cur && target_cur >= `CHZ_CUR_FLOOR) begin
      next_limit = target_cur;
    end
  end

  wire dpm_active = !loop_dis && (dpm_limit < target_cur);

  chz_debounce #(
    .DEB_CYC (DEB_CYC)
  ) u_dpm_deb (
    .ref_clk_i (ref_clk_i),
    .srst_i    (srst_i),
    .level_i   (dpm_active),
    .level_o   (dpm_active_deb)
  );

  wire [12:0] vin_thr = `CHZ_VIN_BASE_MV +
                        `CHZ_VIN_STEP_MV * {10'h0, vin_ctrl[`CHZ_VSEL_HI:`CHZ_VSEL_LO]};

  // Interrupt events
  reg        dpm_deb_q;
  wire [3:0] irq_evt;
  assign irq_evt[`CHZ_IRQ_DPM_BIT]  = dpm_active_deb && !dpm_deb_q;
  assign irq_evt[`CHZ_IRQ_COOL_BIT] = (mode == `CHZ_MODE_SOFT) && (in_cool != cool_q);
  assign irq_evt[`CHZ_IRQ_WARM_BIT] = (mode == `CHZ_MODE_SOFT) && (in_warm != warm_q);
  assign irq_evt[`CHZ_IRQ_DROP_BIT] = vin_low_trip_i && !dpm_trip_q && !loop_dis;

  // Register writes
  always @(posedge ref_clk_i) begin
    if (srst_i) begin
      temp_ctrl <= `CHZ_TEMP_CTRL_RST;
      vin_ctrl  <= `CHZ_VIN_CTRL_RST;
      zone_ctrl <= 4'h0;
      prog_cur  <= `CHZ_CHG_CUR_RST;
      irq_mask  <= 4'h0;
    end else begin
      if (wr_temp) begin
        temp_ctrl <= reg_wdata_i & TEMP_WR_MASK;
      end
      if (wr_vin) begin
        vin_ctrl <= reg_wdata_i & VIN_WR_MASK;
      end
      if (wr_zone) begin
        zone_ctrl <= reg_wdata_i[5:2];
      end
      if (wr_cur) begin
        prog_cur <= reg_wdata_i;
      end
      if (wr_mask) begin
        irq_mask <= reg_wdata_i[3:0];
      end
    end
  end

  // Loop limit and edge history for the event detectors
  always @(posedge ref_clk_i) begin
    if (srst_i) begin
      dpm_limit  <= 8'hff;
      dpm_trip_q <= 1'b0;
      dpm_deb_q  <= 1'b0;
      cool_q     <= 1'b0;
      warm_q     <= 1'b0;
    end else begin
      dpm_limit  <= next_limit;
      dpm_trip_q <= vin_low_trip_i;
      dpm_deb_q  <= dpm_active_deb;
      cool_q     <= in_cool;
      warm_q     <= in_warm;
    end
  end

  // Sticky status, one flop per source; a set wins over a write-one clear
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_irq
      reg  sticky;
      wire clr = wr_stat && reg_wdata_i[gi];
      always @(posedge ref_clk_i) begin
        if (srst_i) begin
          sticky <= 1'b0;
        end else if (irq_evt[gi]) begin
          sticky <= 1'b1;
        end else if (clr) begin
          sticky <= 1'b0;
        end
      end
      assign irq_stat[gi] = sticky;
    end
  endgenerate

  // Read port, data valid the cycle after the strobe
  reg [7:0] rd_mux;
  always @* begin
    case (reg_addr_i)
      `CHZ_TEMP_CTRL_ADDR: rd_mux = temp_ctrl;
      `CHZ_VIN_CTRL_ADDR:  rd_mux = vin_ctrl;
      `CHZ_ZONE_CTRL_ADDR: rd_mux = {2'h0, zone_ctrl, in_cool, in_warm};
      `CHZ_CHG_CUR_ADDR:   rd_mux = prog_cur;
      `CHZ_IRQ_STAT_ADDR:  rd_mux = {4'h0, irq_stat};
      `CHZ_IRQ_MASK_ADDR:  rd_mux = {4'h0, irq_mask};
      `CHZ_LOOP_STAT_ADDR: rd_mux = dpm_limit;
      default:             rd_mux = 8'h00;
    endcase
  end

  always @(posedge ref_clk_i) begin
    if (srst_i)
      reg_rdata_o <= 8'h00;
    else if (reg_rd_i)
      reg_rdata_o <= rd_mux;
    else
      reg_rdata_o <= 8'h00;
  end

  // Registered copies of the configuration
  always @(posedge ref_clk_i) begin
    if (srst_i) begin
      input_regulation_threshold_o <= 13'h0;
      input_low_trip_mv_o          <= 13'h0;
      hot_threshold_select_o       <= 1'b0;
      cold_threshold_select_o      <= 1'b0;
    end else begin
      input_regulation_threshold_o <= vin_thr;
      input_low_trip_mv_o          <= vin_thr - `CHZ_VIN_LOW_OFS_MV;
      hot_threshold_select_o       <= temp_ctrl[`CHZ_HOT_SEL_BIT];
      cold_threshold_select_o      <= temp_ctrl[`CHZ_COLD_SEL_BIT];
    end
  end

  // Charge control; current is the lower of loop limit and zone target, zero in the cold and hot zones
  always @(posedge ref_clk_i) begin
    if (srst_i) begin
      charge_current_o  <= 8'h00;
      cv_reduction_mv_o <= 8'h00;
      charge_enable_o   <= 1'b0;
      zone_o            <= `CHZ_ZONE_NORMAL;
    end else begin
      charge_current_o  <= stop ? 8'h00 :
                           (next_limit < target_cur ? next_limit : target_cur);
      cv_reduction_mv_o <= next_cv_red;
      charge_enable_o   <= !stop;
      zone_o            <= next_zone;
    end
  end

  // Level interrupt, high while an unmasked status bit is set
  always @(posedge ref_clk_i) begin
    if (srst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_stat & irq_mask);
    end
  end

endmodule // chz_charger_ctrl

// ==== dv/chz_supply_therm_model.sv ====
// Behavioural input supply comparators and battery thermistor thresholds
// Assumes the block reports its thresholds in mV and its two select bits
`timescale 1ns/1ps
module chz_supply_therm_model #(
  parameter integer COOL_C = 10,
  parameter integer WARM_C = 45
) (
  input  wire logic [12:0]       vin_mv_i,
  input  wire logic [12:0]       thr_mv_i,
  input  wire logic [12:0]       low_mv_i,
  input  wire logic signed [7:0] temp_i,
  input  wire logic              hot_sel_i,
  input  wire logic              cold_sel_i,
  output logic                   vin_above_o,
  output logic                   vin_low_trip_o,
  output logic                   cold_o,
  output logic                   cool_o,
  output logic                   warm_o,
  output logic                   hot_o
);
  assign vin_above_o    = vin_mv_i > thr_mv_i;
  assign vin_low_trip_o = vin_mv_i <= low_mv_i;
  // Four thresholds split five zones
  assign hot_o  = temp_i >= (hot_sel_i ? 55 : 60);
  assign cold_o = temp_i < (cold_sel_i ? -10 : 0);
  assign warm_o = temp_i > WARM_C;
  assign cool_o = temp_i < COOL_C;
endmodule // chz_supply_therm_model

// ==== dv/chz_charger_ctrl_sva.sv ====
// Port checker for the charger input loop and temperature zone block
// Assumes it is bound into chz_charger_ctrl and sees only its ports
`timescale 1ns/1ps
`include "chz_defines.vh"
module chz_charger_ctrl_sva #(
  parameter integer STEP_CYC = 20
) (
  input wire        ref_clk_i,
  input wire        srst_i,
  input wire [7:0]  reg_addr_i,
  input wire [7:0]  reg_wdata_i,
  input wire        reg_wr_i,
  input wire        reg_rd_i,
  input wire [7:0]  reg_rdata_o,
  input wire        vin_above_i,
  input wire        vin_low_trip_i,
  input wire [12:0] input_regulation_threshold_o,
  input wire [12:0] input_low_trip_mv_o,
  input wire [7:0]  charge_current_o,
  input wire [7:0]  cv_reduction_mv_o,
  input wire        charge_enable_o,
  input wire        hot_threshold_select_o,
  input wire        cold_threshold_select_o,
  input wire [2:0]  zone_o,
  input wire        irq_o
);
  reg  [7:0]  mask_q;
  reg         dis_q;
  reg  [7:0]  prev_cur;
  reg  [2:0]  prev_zone;
  reg  [3:0]  hist;
  reg  [31:0] gap;
  // Quiet: no write and steady zone for four cycles
  wire        quiet = &hist;
  wire        inc   = quiet && (charge_current_o > prev_cur);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);
  always @(posedge ref_clk_i) begin
    prev_cur  <= charge_current_o;
    prev_zone <= zone_o;
    if (srst_i) begin
      mask_q <= 8'h00;
      dis_q  <= 1'b0;
      hist   <= 4'h0;
      gap    <= STEP_CYC;
    end else begin
      hist <= {hist[2:0], !reg_wr_i && (zone_o == prev_zone)};
      gap  <= inc ? 32'h1 : gap + 32'h1;
      if (reg_wr_i && reg_addr_i == `CHZ_IRQ_MASK_ADDR)
        mask_q <= reg_wdata_i;
      if (reg_wr_i && reg_addr_i == `CHZ_VIN_CTRL_ADDR)
        dis_q <= reg_wdata_i[`CHZ_LOOP_DIS_BIT];
    end
  end
  property p_rd_idle;
    !$past(reg_rd_i) |-> reg_rdata_o == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
  property p_low_ofs;
    quiet |-> input_low_trip_mv_o == input_regulation_threshold_o - `CHZ_VIN_LOW_OFS_MV;
  endproperty
  a_low_ofs: assert property (p_low_ofs) else $error("lower trip offset wrong");
  property p_thr;
    quiet |-> input_regulation_threshold_o >= `CHZ_VIN_BASE_MV && input_regulation_threshold_o <= 13'h11f8
      && (input_regulation_threshold_o - `CHZ_VIN_BASE_MV) % `CHZ_VIN_STEP_MV == 13'h0000;
  endproperty
  a_thr: assert property (p_thr) else $error("threshold off grid");
  property p_stop;
    zone_o == `CHZ_ZONE_COLD || zone_o == `CHZ_ZONE_HOT |-> !charge_enable_o && charge_current_o == 8'h00;
  endproperty
  a_stop: assert property (p_stop) else $error("charging in cold or hot zone");
  property p_cv;
    cv_reduction_mv_o != 8'h00 |-> zone_o == `CHZ_ZONE_COOL || zone_o == `CHZ_ZONE_WARM;
  endproperty
  a_cv: assert property (p_cv) else $error("voltage reduced outside cool or warm");
  property p_floor;
    vin_low_trip_i && !dis_q |-> ##[1:2] charge_current_o <= `CHZ_CUR_FLOOR;
  endproperty
  a_floor: assert property (p_floor) else $error("current not dropped on lower trip");
  property p_step_one;
    inc |-> charge_current_o == prev_cur + 8'h01;
  endproperty
  a_step_one: assert property (p_step_one) else $error("current rose by more than one step");
  property p_step_gap;
    inc |-> gap >= STEP_CYC;
  endproperty
  a_step_gap: assert property (p_step_gap) else $error("current steps too close");
  property p_step_above;
    inc |-> $past(vin_above_i) || $past(vin_above_i, 2);
  endproperty
  a_step_above: assert property (p_step_above) else $error("step taken while input low");
  property p_irq;
    irq_o |-> $past(mask_q) != 8'h00;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt with all sources masked");
  property p_sel;
    logic [1:0] v;
    (reg_wr_i && reg_addr_i == `CHZ_TEMP_CTRL_ADDR, v = reg_wdata_i[5:4])
      |-> ##2 {hot_threshold_select_o, cold_threshold_select_o} == v;
  endproperty
  a_sel: assert property (p_sel) else $error("threshold selects not following register");
endmodule // chz_charger_ctrl_sva

bind chz_charger_ctrl chz_charger_ctrl_sva #(.STEP_CYC(STEP_CYC)) u_sva (
  .ref_clk_i, .srst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .vin_above_i,
  .vin_low_trip_i, .input_regulation_threshold_o, .input_low_trip_mv_o, .charge_current_o,
  .cv_reduction_mv_o, .charge_enable_o, .hot_threshold_select_o, .cold_threshold_select_o, .zone_o, .irq_o);

// ==== dv/chz_charger_ctrl_tb.sv ====
// Self-checking bench for the charger input loop and temperature zone block
// Assumes short step and debounce counts and a behavioural supply and thermistor
`timescale 1ns/1ps
`include "chz_defines.vh"
`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin n_errors++; \
  $display("Error %s expected %0h seen %0h", nm, exp, got); end end
module chz_charger_ctrl_tb;
  localparam integer STEP = 20;
  typedef struct {logic [7:0] c92; logic [7:0] c9a; logic signed [7:0] t; logic [2:0] z;
    logic [7:0] cur; logic [7:0] cv; logic en;} chz_row_t;
  // Temperatures in degrees; 8'hfb is minus five
  chz_row_t rows [13] = '{
    '{8'h02, 8'h00, 8'h05, 3'h1, 8'h26, 8'h3c, 1'b1}, '{8'h02, 8'h14, 8'h32, 3'h2, 8'h19, 8'h64, 1'b1},
    '{8'h02, 8'h28, 8'h05, 3'h1, 8'h0c, 8'ha0, 1'b1}, '{8'h02, 8'h3c, 8'h32, 3'h2, 8'h00, 8'hc8, 1'b1},
    '{8'h03, 8'h1c, 8'h32, 3'h2, 8'h19, 8'h00, 1'b1}, '{8'h01, 8'h14, 8'h32, 3'h2, 8'h32, 8'h00, 1'b1},
    '{8'h00, 8'h14, 8'h46, 3'h0, 8'h32, 8'h00, 1'b1}, '{8'h02, 8'h14, 8'h19, 3'h0, 8'h32, 8'h00, 1'b1},
    '{8'h02, 8'h14, 8'h46, 3'h4, 8'h00, 8'h00, 1'b0}, '{8'h03, 8'h14, 8'hfb, 3'h3, 8'h00, 8'h00, 1'b0},
    '{8'h21, 8'h00, 8'h39, 3'h4, 8'h00, 8'h00, 1'b0}, '{8'h11, 8'h00, 8'hfb, 3'h1, 8'h32, 8'h00, 1'b1},
    '{8'h12, 8'h00, 8'hfb, 3'h1, 8'h26, 8'h3c, 1'b1}};
  logic              ref_clk_i = 1'b0;
  logic              srst_i = 1'b1;
  logic [7:0]        reg_addr_i = 8'h00;
  logic [7:0]        reg_wdata_i = 8'h00;
  logic              reg_wr_i = 1'b0;
  logic              reg_rd_i = 1'b0;
  logic [12:0]       vin_mv = 13'h1388;
  logic signed [7:0] temp = 8'h19;
  logic [12:0]       te;
  logic [7:0]        c0;
  wire  [7:0]        reg_rdata_o, charge_current_o, cv_reduction_mv_o;
  wire  [12:0]       input_regulation_threshold_o, input_low_trip_mv_o;
  wire  [2:0]        zone_o;
  wire               charge_enable_o, irq_o, hot_threshold_select_o, cold_threshold_select_o;
  wire               vin_above_i, vin_low_trip_i, therm_cold_i, therm_cool_i, therm_warm_i, therm_hot_i;
  int                n_errors = 0;
  int                num_checks = 0;
  int                cyc = 0;

  always #5 ref_clk_i = ~ref_clk_i;

  chz_charger_ctrl #(.STEP_CYC(STEP), .DEB_CYC(5)) u_dut (
    .ref_clk_i, .srst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .vin_above_i,
    .vin_low_trip_i, .therm_cold_i, .therm_cool_i, .therm_warm_i, .therm_hot_i, .input_regulation_threshold_o,
    .input_low_trip_mv_o, .charge_current_o, .cv_reduction_mv_o, .charge_enable_o, .hot_threshold_select_o,
    .cold_threshold_select_o, .zone_o, .irq_o);

  chz_supply_therm_model u_env (
    .vin_mv_i(vin_mv), .thr_mv_i(input_regulation_threshold_o), .low_mv_i(input_low_trip_mv_o),
    .temp_i(temp), .hot_sel_i(hot_threshold_select_o), .cold_sel_i(cold_threshold_select_o),
    .vin_above_o(vin_above_i), .vin_low_trip_o(vin_low_trip_i), .cold_o(therm_cold_i),
    .cool_o(therm_cool_i), .warm_o(therm_warm_i), .hot_o(therm_hot_i));

  task automatic end_sim;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(posedge ref_clk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= v;
    reg_wr_i    <= 1'b1;
    @(posedge ref_clk_i);
    reg_wr_i    <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge ref_clk_i);
    reg_rd_i   <= 1'b0;
    @(negedge ref_clk_i);
    `CHK("rdata", exp, reg_rdata_o & m)
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
  endtask

  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_errors++;
      end_sim();
    end
  end

  initial begin
    repeat (20) @(posedge ref_clk_i);
    srst_i <= 1'b0;
    rd_chk(`CHZ_TEMP_CTRL_ADDR, 8'hff, `CHZ_TEMP_CTRL_RST);
    rd_chk(`CHZ_VIN_CTRL_ADDR, 8'hff, `CHZ_VIN_CTRL_RST);
    rd_chk(`CHZ_ZONE_CTRL_ADDR, 8'hff, `CHZ_ZONE_CTRL_RST);
    rd_chk(`CHZ_CHG_CUR_ADDR, 8'hff, `CHZ_CHG_CUR_RST);
    wr_reg(`CHZ_TEMP_CTRL_ADDR, 8'hff);
    rd_chk(`CHZ_TEMP_CTRL_ADDR, 8'hff, 8'hbf);
    wr_reg(`CHZ_VIN_CTRL_ADDR, 8'hff);
    rd_chk(`CHZ_VIN_CTRL_ADDR, 8'hff, 8'h3f);
    wr_reg(`CHZ_ZONE_CTRL_ADDR, 8'hff);
    rd_chk(`CHZ_ZONE_CTRL_ADDR, 8'hfc, 8'h3c);
    wr_reg(8'h10, 8'hff);
    rd_chk(8'h10, 8'hff, 8'h00);
    $display("test access done");
    for (int i = 0; i < 13; i++) begin
      wr_reg(`CHZ_VIN_CTRL_ADDR, {5'h04, i[2:0]});
      wr_reg(`CHZ_TEMP_CTRL_ADDR, rows[i].c92);
      wr_reg(`CHZ_ZONE_CTRL_ADDR, rows[i].c9a);
      temp <= rows[i].t;
      te = `CHZ_VIN_BASE_MV + `CHZ_VIN_STEP_MV * {10'h000, i[2:0]};
      settle(4);
      `CHK("threshold", te, input_regulation_threshold_o)
      `CHK("low trip", te - `CHZ_VIN_LOW_OFS_MV, input_low_trip_mv_o)
      `CHK("zone", rows[i].z, zone_o)
      `CHK("current", rows[i].cur, charge_current_o)
      `CHK("cv reduction", rows[i].cv, cv_reduction_mv_o)
      `CHK("enable", rows[i].en, charge_enable_o)
      `CHK("irq masked", 1'b0, irq_o)
    end
    $display("test zones done");
    wr_reg(`CHZ_TEMP_CTRL_ADDR, 8'h04);
    temp <= 8'h19;
    wr_reg(`CHZ_IRQ_STAT_ADDR, 8'hff);
    wr_reg(`CHZ_VIN_CTRL_ADDR, 8'h06);
    vin_mv <= 13'h10cc;
    settle(4);
    `CHK("floor", `CHZ_CUR_FLOOR, charge_current_o)
    @(posedge ref_clk_i);
    vin_mv <= 13'h11f8;
    settle(10 * STEP);
    `CHK("ramp", 1'b1, charge_current_o >= 8'h12 && charge_current_o <= 8'h15)
    c0 = charge_current_o;
    @(posedge ref_clk_i);
    vin_mv <= 13'h1130;
    settle(5 * STEP);
    `CHK("no rise below", 1'b1, charge_current_o < c0)
    rd_chk(`CHZ_IRQ_STAT_ADDR, 8'hff, 8'h09);
    wr_reg(`CHZ_IRQ_MASK_ADDR, 8'h08);
    settle(2);
    `CHK("irq", 1'b1, irq_o)
    wr_reg(`CHZ_IRQ_STAT_ADDR, 8'h08);
    settle(2);
    `CHK("irq cleared", 1'b0, irq_o)
    wr_reg(`CHZ_TEMP_CTRL_ADDR, 8'h01);
    temp <= 8'h05;
    settle(4);
    rd_chk(`CHZ_IRQ_STAT_ADDR, 8'h02, 8'h02);
    $display("test input loop done");
    end_sim();
  end
endmodule // chz_charger_ctrl_tb
